// ===== hw/pin_mux_pkg.sv
// Purpose: shared constants for the strap and pin multiplexer
// Assumes: APB byte addresses, 32-bit data, one word per register
// Notes:   straps are active only until the first edge after reset release
package pin_mux_pkg;
	localparam int unsigned ADDR_W = 14; // external address pins
	localparam int unsigned DATA_W = 24; // external data pins
	localparam int unsigned HI_W   = 8;  // upper lines reused for byte address
	localparam int unsigned LO_W   = DATA_W - HI_W;
	localparam int unsigned HOST_W = 16; // host address/data pins
	localparam int unsigned FLAG_N = 8;  // general-purpose flag pins
	localparam int unsigned STRAP_N = 3; // mode straps on flags 2:0
	localparam int unsigned STRAP_MEM = 2; // memory mode strap
	localparam int unsigned SP_N   = 4;  // serial port pins under the mux
	localparam int unsigned IRQ_N  = 6;  // external interrupt sources
	localparam int unsigned CTRL_W = 4;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_FDIR = 8'h04;
	localparam logic [7:0] OFS_FOUT = 8'h08;
	localparam logic [7:0] OFS_FIN  = 8'h0c;
	localparam logic [7:0] OFS_MODE = 8'h10;
	localparam logic [7:0] OFS_MASK = 8'h14;
	localparam logic [7:0] OFS_PEND = 8'h18;

	// control bits
	localparam int unsigned CTL_SP_ALT   = 0;
	localparam int unsigned CTL_CFG_EDG  = 1;
	localparam int unsigned CTL_RFS_EDG  = 2;
	localparam int unsigned CTL_TFS_EDG  = 3;
	localparam int unsigned FOUT_ALT     = 8; // serial alternate flag output bit

	// flag pins that double as interrupt requests
	localparam int unsigned PIN_EDGE_REQ = 4;
	localparam int unsigned PIN_LVL0_REQ = 5;
	localparam int unsigned PIN_LVL1_REQ = 6;
	localparam int unsigned PIN_CFG_REQ  = 7;

	// serial port pin slots
	localparam int unsigned SP_DR  = 0;
	localparam int unsigned SP_DT  = 1;
	localparam int unsigned SP_RFS = 2;
	localparam int unsigned SP_TFS = 3;

	// interrupt sources, highest priority first
	localparam int unsigned SRC_CFG     = 0;
	localparam int unsigned SRC_LVL1    = 1;
	localparam int unsigned SRC_LVL0    = 2;
	localparam int unsigned SRC_EDGE    = 3;
	localparam int unsigned SRC_TFS_ALT = 4;
	localparam int unsigned SRC_RFS_ALT = 5;
	localparam logic [ADDR_W-1:0] VEC_ADDR [IRQ_N] = '{14'h0004, 14'h0008,
		14'h000c, 14'h0018, 14'h0020, 14'h0024};

	localparam logic [ADDR_W-1:0] HOST_ADDR_OE = 14'h0001; // lowest line only
	localparam logic MEM_HOST = 1'b1;
	localparam logic [3:0] HS_IDLE = 4'hd; // strobes high, latch low

	typedef enum logic {BOOT_STRAP = 1'b0, BOOT_RUN = 1'b1} boot_t;
endpackage

// ===== hw/pin_mux.sv
// Purpose: reset-time memory mode, flag/interrupt pin sharing, serial pin alternates
// Assumes: pins synchronous to pclk; interrupt pins active low
// Notes:   all pin outputs are registered, one cycle behind their sources
// Operation
// - memory mode fixed from reset strap
// - strap 0: 14 address, 24 data lines
// - strap 1: host port, one address, 16 data
// - full mode byte access: upper eight carry address
// - straps sampled on first edge after reset release, then plain flags
// - bus pins fixed at reset, serial anytime
// - interrupt and flag functions active together
// - serial pins become interrupts and flags
// - unmasked asserted shared pin gives its vector
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ns
`default_nettype none
module pin_mux (
	input  wire logic               pclk,           // 250 MHz clock
	input  wire logic               presetn,        // async reset, low
	input  wire logic               psel,           // apb select
	input  wire logic               penable,        // apb access phase
	input  wire logic               pwrite,         // apb direction
	input  wire logic [7:0]         paddr,          // apb byte address
	input  wire logic [31:0]        pwdata,         // apb write data
	output logic      [31:0]        prdata,         // apb read data
	output logic                    pready,         // apb ready
	output logic                    pslverr,        // unmapped address
	input  wire logic [7:0]         gp_flag_i,      // flag pad levels
	output logic      [7:0]         gp_flag_o,      // flag drive values
	output logic      [7:0]         gp_flag_oe,     // flag drive enables
	input  wire logic [13:0]        core_addr,      // core address
	input  wire logic [23:0]        core_wdata,     // core write data
	input  wire logic               core_wr,        // core drives data
	input  wire logic               core_byte,      // byte space access
	input  wire logic [7:0]         core_byte_hi,   // byte address top
	output logic      [23:0]        core_rdata,     // data pad capture
	output logic      [13:0]        ext_addr_o,     // address pins
	output logic      [13:0]        ext_addr_oe,    // address enables
	input  wire logic [23:0]        ext_data_i,     // data pad levels
	output logic      [23:0]        ext_data_o,     // data drive
	output logic      [23:0]        ext_data_oe,    // data enables
	input  wire logic [15:0]        host_ad_i,      // host bus pads
	output logic      [15:0]        host_ad_o,      // host bus drive
	output logic      [15:0]        host_ad_oe,     // host bus enables
	input  wire logic               host_write_strobe_n, // host write
	input  wire logic               host_read_strobe_n,  // host read
	input  wire logic               host_address_latch,  // host latch
	input  wire logic               host_port_select_n,  // host select
	output logic                    host_port_acknowledge_n, // host ack
	input  wire logic [15:0]        hp_ad_o,        // engine drive
	input  wire logic [15:0]        hp_ad_oe,       // engine enables
	input  wire logic               hp_ack_n,       // engine ack
	output logic      [15:0]        hp_ad_i,        // to engine
	output logic      [3:0]         hp_strobe,      // wr_n,rd_n,al,sel_n
	input  wire logic [3:0]         sp_pin_i,       // serial pad levels
	output logic      [3:0]         sp_pin_o,       // serial drive
	output logic      [3:0]         sp_pin_oe,      // serial enables
	input  wire logic [3:0]         sport_o,        // serial port drive
	input  wire logic [3:0]         sport_oe,       // serial port enables
	output logic      [3:0]         sport_i,        // to serial port
	input  wire logic [5:0]         irq_clr,        // pending clears
	output logic                    irq_vec_req,    // vector request
	output logic      [13:0]        irq_vec_addr    // service address
);
	localparam int unsigned IN = pin_mux_pkg::IRQ_N;

	// register decode for the error answer; the read mux decodes on its own
	function automatic logic mapped(input logic [7:0] a);
		mapped = a inside {pin_mux_pkg::OFS_CTRL, pin_mux_pkg::OFS_FDIR,
			pin_mux_pkg::OFS_FOUT, pin_mux_pkg::OFS_FIN, pin_mux_pkg::OFS_MODE,
			pin_mux_pkg::OFS_MASK, pin_mux_pkg::OFS_PEND};
	endfunction

	pin_mux_pkg::boot_t st_ff, nxt_st;
	logic [2:0]  strap_ff, nxt_strap;
	logic [3:0]  ctrl_ff, nxt_ctrl;
	logic [7:0]  fdir_ff, nxt_fdir;
	logic [8:0]  fout_ff, nxt_fout;
	logic [5:0]  mask_ff, nxt_mask;
	logic [31:0] prdata_ff, nxt_prdata;
	logic [5:0]  prev_ff, nxt_prev, pend_ff, nxt_pend;
	logic        vreq_ff, nxt_vreq;
	logic [13:0] vaddr_ff, nxt_vaddr;
	logic [7:0]  fdrv_ff, nxt_fdrv, foe_ff, nxt_foe;
	logic [13:0] ao_ff, nxt_ao, aoe_ff, nxt_aoe;
	logic [23:0] do_ff, nxt_do, doe_ff, nxt_doe, di_ff, nxt_di;
	logic [15:0] ho_ff, nxt_ho, hoe_ff, nxt_hoe, hi_ff, nxt_hi;
	logic        hack_ff, nxt_hack;
	logic [3:0]  hs_ff, nxt_hs, so_ff, nxt_so, soe_ff, nxt_soe, si_ff, nxt_si;
	logic        run, host, alt;
	logic [7:0]  eff;
	logic [5:0]  act, edg, lvl_req;

	assign run  = (st_ff == pin_mux_pkg::BOOT_RUN);
	assign host = (strap_ff[pin_mux_pkg::STRAP_MEM] == pin_mux_pkg::MEM_HOST);
	assign alt  = ctrl_ff[pin_mux_pkg::CTL_SP_ALT];
	// own drive counts as assertion, so a flag output can raise its interrupt
	assign eff  = (foe_ff & fdrv_ff) | (~foe_ff & gp_flag_i);

	// interrupt side of shared pins, never gated by flag direction
	always_comb begin
		act = '0;
		act[pin_mux_pkg::SRC_CFG]  = ~eff[pin_mux_pkg::PIN_CFG_REQ];
		act[pin_mux_pkg::SRC_LVL1] = ~eff[pin_mux_pkg::PIN_LVL1_REQ];
		act[pin_mux_pkg::SRC_LVL0] = ~eff[pin_mux_pkg::PIN_LVL0_REQ];
		act[pin_mux_pkg::SRC_EDGE] = ~eff[pin_mux_pkg::PIN_EDGE_REQ];
		act[pin_mux_pkg::SRC_TFS_ALT] = alt & ~sp_pin_i[pin_mux_pkg::SP_TFS];
		act[pin_mux_pkg::SRC_RFS_ALT] = alt & ~sp_pin_i[pin_mux_pkg::SP_RFS];
		edg = '0;
		edg[pin_mux_pkg::SRC_EDGE] = 1'b1;
		edg[pin_mux_pkg::SRC_CFG] = ctrl_ff[pin_mux_pkg::CTL_CFG_EDG];
		edg[pin_mux_pkg::SRC_TFS_ALT] = ctrl_ff[pin_mux_pkg::CTL_TFS_EDG];
		edg[pin_mux_pkg::SRC_RFS_ALT] = ctrl_ff[pin_mux_pkg::CTL_RFS_EDG];
		lvl_req = (pend_ff & edg) | (act & ~edg);
	end

	// pending, priority pick and vector; a new edge beats a same-cycle clear
	always_comb begin
		nxt_prev  = act;
		nxt_pend  = (pend_ff & ~irq_clr) | (act & ~prev_ff & edg);
		nxt_vreq  = |(lvl_req & mask_ff);
		nxt_vaddr = vaddr_ff;
		for (int i = IN - 1; i >= 0; i--) begin
			if (lvl_req[i] && mask_ff[i]) begin
				nxt_vaddr = pin_mux_pkg::VEC_ADDR[i];
			end
		end
	end

	// strap capture on the first edge after release, then held
	always_comb begin
		nxt_st    = st_ff;
		nxt_strap = strap_ff;
		unique case (st_ff)
			pin_mux_pkg::BOOT_STRAP: begin
				nxt_strap = gp_flag_i[pin_mux_pkg::STRAP_N-1:0];
				nxt_st    = pin_mux_pkg::BOOT_RUN;
			end
			pin_mux_pkg::BOOT_RUN: begin
				nxt_strap = strap_ff;
			end
		endcase
	end

	// apb registers; read data taken in setup so access needs no wait
	always_comb begin
		nxt_ctrl   = ctrl_ff;
		nxt_fdir   = fdir_ff;
		nxt_fout   = fout_ff;
		nxt_mask   = mask_ff;
		nxt_prdata = prdata_ff;
		if (psel && penable && pwrite) begin
			unique case (paddr)
				pin_mux_pkg::OFS_CTRL: nxt_ctrl = pwdata[3:0];
				pin_mux_pkg::OFS_FDIR: nxt_fdir = pwdata[7:0];
				pin_mux_pkg::OFS_FOUT: nxt_fout = pwdata[8:0];
				pin_mux_pkg::OFS_MASK: nxt_mask = pwdata[5:0];
				default: ;
			endcase
		end
		if (psel && !penable && !pwrite) begin
			nxt_prdata = '0;
			unique case (paddr)
				pin_mux_pkg::OFS_CTRL: nxt_prdata[3:0] = ctrl_ff;
				pin_mux_pkg::OFS_FDIR: nxt_prdata[7:0] = fdir_ff;
				pin_mux_pkg::OFS_FOUT: nxt_prdata[8:0] = fout_ff;
				pin_mux_pkg::OFS_FIN: nxt_prdata[8:0] =
					{sp_pin_i[pin_mux_pkg::SP_DR], gp_flag_i};
				pin_mux_pkg::OFS_MODE: nxt_prdata[3:0] = {run, strap_ff};
				pin_mux_pkg::OFS_MASK: nxt_prdata[5:0] = mask_ff;
				pin_mux_pkg::OFS_PEND: nxt_prdata[5:0] = lvl_req;
				default: ;
			endcase
		end
	end

	// pin multiplexing; bus roles follow only the captured mode
	always_comb begin
		nxt_fdrv = fout_ff[7:0];
		nxt_foe  = run ? fdir_ff : '0;
		nxt_ao   = core_addr;
		nxt_aoe  = '0;
		nxt_do   = core_wdata;
		nxt_doe  = '0;
		nxt_di   = ext_data_i;
		nxt_ho   = hp_ad_o;
		nxt_hoe  = '0;
		nxt_hi   = '0;
		nxt_hack = 1'b1;
		nxt_hs   = pin_mux_pkg::HS_IDLE; // idle: strobes high, latch low
		if (run && !host) begin
			nxt_aoe = '1;
			nxt_doe = {{pin_mux_pkg::HI_W{core_wr | core_byte}},
				{pin_mux_pkg::LO_W{core_wr}}};
			if (core_byte) begin
				nxt_do[pin_mux_pkg::DATA_W-1:pin_mux_pkg::LO_W] = core_byte_hi;
			end
		end else if (run) begin
			nxt_aoe  = pin_mux_pkg::HOST_ADDR_OE;
			nxt_doe  = {{pin_mux_pkg::LO_W{core_wr}}, {pin_mux_pkg::HI_W{1'b0}}};
			nxt_di[pin_mux_pkg::HI_W-1:0] = '0;
			nxt_hoe  = hp_ad_oe;
			nxt_hi   = host_ad_i;
			nxt_hack = hp_ack_n;
			nxt_hs   = {host_write_strobe_n, host_read_strobe_n,
				host_address_latch, host_port_select_n};
		end
		// serial pins may flip at any time under software control
		if (alt) begin
			nxt_so  = '0;
			nxt_so[pin_mux_pkg::SP_DT] = fout_ff[pin_mux_pkg::FOUT_ALT];
			nxt_soe = '0;
			nxt_soe[pin_mux_pkg::SP_DT] = 1'b1;
			nxt_si  = '1; // serial port sees idle frames
		end else begin
			nxt_so  = sport_o;
			nxt_soe = sport_oe;
			nxt_si  = sp_pin_i;
		end
	end

	// state registers; async reset loads constants only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= pin_mux_pkg::BOOT_STRAP;
			strap_ff <= '0;
			ctrl_ff <= '0;
			fdir_ff <= '0;
			fout_ff <= '0;
			mask_ff <= '0;
			prdata_ff <= '0;
			prev_ff <= '0;
			pend_ff <= '0;
			vreq_ff <= 1'b0;
			vaddr_ff <= '0;
			fdrv_ff <= '0;
			foe_ff <= '0;
			ao_ff <= '0;
			aoe_ff <= '0;
			do_ff <= '0;
			doe_ff <= '0;
			di_ff <= '0;
			ho_ff <= '0;
			hoe_ff <= '0;
			hi_ff <= '0;
			hack_ff <= 1'b1;
			hs_ff <= pin_mux_pkg::HS_IDLE;
			so_ff <= '0;
			soe_ff <= '0;
			si_ff <= '0;
		end else begin
			st_ff <= nxt_st;
			strap_ff <= nxt_strap;
			ctrl_ff <= nxt_ctrl;
			fdir_ff <= nxt_fdir;
			fout_ff <= nxt_fout;
			mask_ff <= nxt_mask;
			prdata_ff <= nxt_prdata;
			prev_ff <= nxt_prev;
			pend_ff <= nxt_pend;
			vreq_ff <= nxt_vreq;
			vaddr_ff <= nxt_vaddr;
			fdrv_ff <= nxt_fdrv;
			foe_ff <= nxt_foe;
			ao_ff <= nxt_ao;
			aoe_ff <= nxt_aoe;
			do_ff <= nxt_do;
			doe_ff <= nxt_doe;
			di_ff <= nxt_di;
			ho_ff <= nxt_ho;
			hoe_ff <= nxt_hoe;
			hi_ff <= nxt_hi;
			hack_ff <= nxt_hack;
			hs_ff <= nxt_hs;
			so_ff <= nxt_so;
			soe_ff <= nxt_soe;
			si_ff <= nxt_si;
		end
	end

	// outputs
	assign prdata = prdata_ff;
	assign pready = 1'b1; // zero wait states
	assign pslverr = psel & penable & ~mapped(paddr);
	assign gp_flag_o = fdrv_ff;
	assign gp_flag_oe = foe_ff;
	assign core_rdata = di_ff;
	assign ext_addr_o = ao_ff;
	assign ext_addr_oe = aoe_ff;
	assign ext_data_o = do_ff;
	assign ext_data_oe = doe_ff;
	assign host_ad_o = ho_ff;
	assign host_ad_oe = hoe_ff;
	assign host_port_acknowledge_n = hack_ff;
	assign hp_ad_i = hi_ff;
	assign hp_strobe = hs_ff;
	assign sp_pin_o = so_ff;
	assign sp_pin_oe = soe_ff;
	assign sport_i = si_ff;
	assign irq_vec_req = vreq_ff;
	assign irq_vec_addr = vaddr_ff;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_mode_hold: assert property (run |=> run && $stable(strap_ff))
		else $error("memory mode changed while running");
	a_strap_capture: assert property (!run |=> run ##0
		strap_ff == $past(gp_flag_i[2:0]))
		else $error("strap not captured at release");
	a_strap_quiet: assert property (!run |-> gp_flag_oe == '0 && ext_addr_oe == '0)
		else $error("pins driven during strap sampling");
	a_full_bus: assert property (run && !host && core_wr && !core_byte |=>
		ext_addr_oe == '1 && ext_data_oe == '1 && ext_data_o == $past(core_wdata))
		else $error("full mode bus wrong");
	a_host_bus: assert property (run && host |=> ext_addr_oe == pin_mux_pkg::HOST_ADDR_OE
		&& ext_data_oe[7:0] == '0 && host_ad_oe == $past(hp_ad_oe))
		else $error("host mode pins wrong");
	a_byte_upper: assert property (run && !host && core_byte |=>
		ext_data_o[23:16] == $past(core_byte_hi) && ext_data_oe[23:16] == '1)
		else $error("byte address not on upper lines");
	a_serial_alt: assert property (alt |=> sp_pin_oe == 4'h2
		&& sp_pin_o[1] == $past(fout_ff[8]) && sport_i == '1)
		else $error("serial alternate pins wrong");
	a_flag_irq: assert property (gp_flag_oe[7] && !gp_flag_o[7] && mask_ff[0]
		&& !ctrl_ff[1] |=> irq_vec_req && irq_vec_addr == 14'h0004)
		else $error("own flag drive did not raise interrupt");
	a_vec_prio: assert property (lvl_req[3] && mask_ff[3] && !(|(lvl_req[2:0]
		& mask_ff[2:0])) |=> irq_vec_addr == 14'h0018)
		else $error("wrong vector chosen");
endmodule // pin_mux
`default_nettype wire

// ===== dv/pad_model.sv
// Purpose: board side of the pins: pads, pull-ups, outside drivers
// Assumes: flag pins carry weak pull-ups; serial lines are always driven outside
// Notes:   floating data pads toggle every cycle so no stale value survives
`timescale 1ns/1ns
`default_nettype none
module pad_model (
	input  wire logic        pclk,       // clock
	input  wire logic [7:0]  flag_o,     // flag drive
	input  wire logic [7:0]  flag_oe,    // flag enables
	input  wire logic [7:0]  flag_ext,   // outside flag level
	input  wire logic [7:0]  flag_en,    // outside flag enables
	input  wire logic [23:0] data_o,     // data drive
	input  wire logic [23:0] data_oe,    // data enables
	input  wire logic [3:0]  sp_o,       // serial drive
	input  wire logic [3:0]  sp_oe,      // serial enables
	input  wire logic [3:0]  sp_ext,     // outside serial level
	input  wire logic [13:0] addr_o,     // address pins
	input  wire logic [13:0] addr_oe,    // address enables
	output logic      [7:0]  flag_i,     // flag pad levels
	output logic      [23:0] data_i,     // data pad levels
	output logic      [3:0]  sp_i,       // serial pad levels
	output logic             periph_hi   // peripheral decode
);
	logic [23:0] float_ff = 24'h5a5a5a;
	// floating pattern, inverted each cycle
	always @(posedge pclk) float_ff <= ~float_ff;
	// wired levels: pull-up wins only when nobody drives
	assign flag_i = (flag_oe & flag_o) | (~flag_oe & ((flag_en & flag_ext) | ~flag_en));
	assign data_i = (data_oe & data_o) | (~data_oe & float_ff);
	assign sp_i = (sp_oe & sp_o) | (~sp_oe & sp_ext);
	// outside logic picks its peripheral from the lowest line
	assign periph_hi = addr_oe[0] & addr_o[0];
endmodule // pad_model
`default_nettype wire

// ===== dv/testbench.sv
// Purpose: self-checking bench for the pin multiplexer
// Assumes: pready may stall; only the watchdog bounds a wait
// Notes:   each mode scenario resets with its own strap levels
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_err;
	logic        core_wr, core_byte, hp_ack_n, ack_n, vec_req, wr_n, rd_n, al, sel_n, periph_hi;
	logic [7:0]  paddr, flag_i, flag_o, flag_oe, byte_hi, flag_ext, flag_en;
	logic [31:0] pwdata, prdata, rd_val;
	logic [13:0] core_addr, addr_o, addr_oe, vec_addr;
	logic [23:0] core_wdata, core_rdata, data_i, data_o, data_oe;
	logic [15:0] host_i, host_o, host_oe, hp_o, hp_oe, hp_i;
	logic [3:0]  hp_strobe, sp_i, sp_o, sp_oe, sport_o, sport_oe, sport_i, sp_ext;
	logic [5:0]  irq_clr;
	int          num_errors, cmp_count;

	pin_mux DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .gp_flag_i(flag_i), .gp_flag_o(flag_o),
		.gp_flag_oe(flag_oe), .core_addr(core_addr), .core_wdata(core_wdata),
		.core_wr(core_wr), .core_byte(core_byte), .core_byte_hi(byte_hi),
		.core_rdata(core_rdata), .ext_addr_o(addr_o), .ext_addr_oe(addr_oe),
		.ext_data_i(data_i), .ext_data_o(data_o), .ext_data_oe(data_oe),
		.host_ad_i(host_i), .host_ad_o(host_o), .host_ad_oe(host_oe),
		.host_write_strobe_n(wr_n), .host_read_strobe_n(rd_n),
		.host_address_latch(al), .host_port_select_n(sel_n),
		.host_port_acknowledge_n(ack_n), .hp_ad_o(hp_o), .hp_ad_oe(hp_oe),
		.hp_ack_n(hp_ack_n), .hp_ad_i(hp_i), .hp_strobe(hp_strobe), .sp_pin_i(sp_i),
		.sp_pin_o(sp_o), .sp_pin_oe(sp_oe), .sport_o(sport_o), .sport_oe(sport_oe),
		.sport_i(sport_i), .irq_clr(irq_clr), .irq_vec_req(vec_req),
		.irq_vec_addr(vec_addr));
	pad_model pads (.pclk(pclk), .flag_o(flag_o), .flag_oe(flag_oe),
		.flag_ext(flag_ext), .flag_en(flag_en), .data_o(data_o), .data_oe(data_oe),
		.sp_o(sp_o), .sp_oe(sp_oe), .sp_ext(sp_ext), .addr_o(addr_o),
		.addr_oe(addr_oe), .flag_i(flag_i), .data_i(data_i), .sp_i(sp_i),
		.periph_hi(periph_hi));

	// 250 MHz clock
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask

	// one apb transfer; the idle edge before it keeps psel single-driven
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd_val = prdata;
		rd_err = pslverr;
		{psel, penable} <= 2'b00;
	endtask

	// straps driven while reset is low and one cycle after, released after capture
	task automatic do_reset(input logic [2:0] s);
		@(posedge pclk);
		presetn <= 1'b0;
		flag_ext <= {5'h1f, s};
		flag_en <= 8'h07;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		flag_en <= 8'h00;
		settle(2);
	endtask

	task automatic t_full_mode();
		do_reset(3'b011);
		apb(1'b0, pin_mux_pkg::OFS_MODE, 32'h0);
		chk(rd_val, 32'h0000000b);
		@(posedge pclk);
		{core_addr, core_byte, byte_hi} <= {14'h2a5c, 1'b1, 8'hc3};
		settle(2);
		chk(32'(addr_oe), 32'h3fff);
		chk(32'(addr_o), 32'h2a5c);
		chk(32'(data_oe[23:16]), 32'hff);
		chk(32'(data_o[23:16]), 32'hc3);
		chk(32'(host_oe), 32'h0);
		@(posedge pclk);
		{core_byte, core_wr, core_wdata} <= {1'b0, 1'b1, 24'h5a1234};
		settle(2);
		chk(32'(data_oe), 32'hffffff);
		chk(32'(data_o), 32'h5a1234);
		chk(32'(core_rdata), 32'h5a1234);
		// straps turned the other way while running must change nothing
		@(posedge pclk);
		{flag_ext, flag_en} <= {8'hfc, 8'h07};
		apb(1'b1, pin_mux_pkg::OFS_MODE, 32'h0);
		apb(1'b0, pin_mux_pkg::OFS_MODE, 32'h0);
		chk(rd_val, 32'h0000000b);
		apb(1'b0, pin_mux_pkg::OFS_FIN, 32'h0);
		chk(rd_val, 32'h000000fc);
		@(posedge pclk);
		flag_en <= 8'h00;
		apb(1'b1, pin_mux_pkg::OFS_FDIR, 32'h4);
		settle(2);
		chk(32'(flag_oe), 32'h04);
		apb(1'b0, pin_mux_pkg::OFS_FIN, 32'h0);
		chk(rd_val, 32'h000000fb);
		apb(1'b0, 8'h40, 32'h0);
		chk(32'(rd_err), 32'h1);
		chk(rd_val, 32'h0);
	endtask

	task automatic t_irq_flag();
		apb(1'b1, pin_mux_pkg::OFS_MASK, 32'h08);
		apb(1'b1, pin_mux_pkg::OFS_FDIR, 32'h10);
		settle(4);
		chk(32'(vec_req), 32'h1);
		chk(32'(vec_addr), 32'h0018);
		apb(1'b0, pin_mux_pkg::OFS_FIN, 32'h0);
		chk(rd_val, 32'h000000ef);
		@(posedge pclk);
		irq_clr <= 6'h08;
		@(posedge pclk);
		irq_clr <= 6'h00;
		settle(2);
		chk(32'(vec_req), 32'h0);
		// flag 7 driven low by its own output raises the top vector
		apb(1'b1, pin_mux_pkg::OFS_MASK, 32'h09);
		apb(1'b1, pin_mux_pkg::OFS_FDIR, 32'h90);
		settle(3);
		chk(32'(vec_addr), 32'h0004);
		apb(1'b1, pin_mux_pkg::OFS_CTRL, 32'h02);
		apb(1'b1, pin_mux_pkg::OFS_FDIR, 32'h10);
		settle(2);
		chk(32'(vec_req), 32'h0);
		// new falling edge meets a clear in the same cycle: the edge wins
		apb(1'b1, pin_mux_pkg::OFS_FDIR, 32'h90);
		@(posedge pclk);
		irq_clr <= 6'h01;
		@(posedge pclk);
		irq_clr <= 6'h00;
		settle(2);
		chk(32'(vec_req), 32'h1);
		chk(32'(vec_addr), 32'h0004);
	endtask

	task automatic t_host_mode();
		do_reset(3'b100);
		apb(1'b0, pin_mux_pkg::OFS_MODE, 32'h0);
		chk(rd_val, 32'h0000000c);
		@(posedge pclk);
		{core_addr, hp_o, hp_oe, hp_ack_n} <= {14'h3fff, 16'hbeef, 16'hffff, 1'b0};
		{host_i, wr_n, rd_n, al, sel_n} <= {16'h1357, 4'h6};
		settle(2);
		chk(32'(addr_oe), 32'h0001);
		chk(32'(data_oe), 32'hffff00);
		chk(32'(data_o[23:8]), 32'h5a12);
		chk(32'(host_o), 32'hbeef);
		chk(32'(host_oe), 32'hffff);
		chk(32'(ack_n), 32'h0);
		chk(32'(hp_i), 32'h1357);
		chk(32'(hp_strobe), 32'h6);
		chk(32'(core_rdata), 32'h5a1200);
		chk(32'(periph_hi), 32'h1);
	endtask

	task automatic t_serial_alt();
		@(posedge pclk);
		{sport_o, sport_oe, sp_ext} <= {4'h5, 4'h3, 4'ha};
		settle(3);
		chk(32'(sp_oe), 32'h3);
		chk(32'(sport_i), 32'h9);
		apb(1'b1, pin_mux_pkg::OFS_MASK, 32'h20);
		apb(1'b1, pin_mux_pkg::OFS_FOUT, 32'h100);
		apb(1'b1, pin_mux_pkg::OFS_CTRL, 32'h1);
		@(posedge pclk);
		sp_ext <= 4'h3;
		settle(3);
		chk(32'(sp_oe), 32'h2);
		chk(32'(sp_o[1]), 32'h1);
		chk(32'(sport_i), 32'hf);
		chk(32'(vec_addr), 32'h0024);
		apb(1'b0, pin_mux_pkg::OFS_FIN, 32'h0);
		chk(rd_val & 32'h100, 32'h100);
		apb(1'b1, pin_mux_pkg::OFS_MASK, 32'h30);
		settle(2);
		chk(32'(vec_addr), 32'h0020);
		// tfs made edge sensitive while held low: no new request from it
		apb(1'b1, pin_mux_pkg::OFS_CTRL, 32'h09);
		settle(2);
		chk(32'(vec_addr), 32'h0024);
		apb(1'b1, pin_mux_pkg::OFS_CTRL, 32'h0);
		settle(2);
		chk(32'(sp_oe), 32'h3);
	endtask

	// main sequence
	initial begin
		num_errors = 0;
		cmp_count = 0;
		{presetn, psel, penable, pwrite, core_wr, core_byte, al} = '0;
		{hp_ack_n, wr_n, rd_n, sel_n} = 4'hf;
		{paddr, pwdata, core_addr, core_wdata, byte_hi, host_i, hp_o, hp_oe} = '0;
		{sport_o, sport_oe, sp_ext, irq_clr, flag_ext, flag_en} = '0;
		t_full_mode();
		t_irq_flag();
		t_host_mode();
		t_serial_alt();
		end_of_test();
	end

	// hang guard, far beyond the roughly 130 cycles needed
	initial begin
		#40000;
		num_errors++;
		end_of_test();
	end
endmodule // testbench
`default_nettype wire
